// >>> rtl/dpsc_ctrl.v
// dual potentiometer serial command controller, write-only three-wire link
`timescale 1ns/1ps
`include "dpsc_defs.vh"

module dpsc_ctrl (
	sys_clk,
	sys_rst,
	ser_clk,
	ser_data,
	ser_cs_n,
	wiper_position_a,
	wiper_position_b,
	stored_position_a,
	stored_position_b,
	init_done,
	store_busy
);
	input  wire       sys_clk;
	input  wire       sys_rst;
	input  wire       ser_clk;
	input  wire       ser_data;
	input  wire       ser_cs_n;
	output reg  [7:0] wiper_position_a;
	output reg  [7:0] wiper_position_b;
	output reg  [7:0] stored_position_a;
	output reg  [7:0] stored_position_b;
	output reg        init_done;
	output reg        store_busy;

	// --------------------------------------------------------------
	// notes on use
	// --------------------------------------------------------------
	// the link is sampled, not clocked: each serial clock level must
	// last at least three system clocks or a rising edge can be missed
	// a frame takes effect about three system clocks after chip select
	// rises, once the select pin has passed its synchroniser
	// the stored copies are ordinary flops that reset to midscale, so
	// a system reset stands in for a power cycle of the stored memory
	// bits clocked in before the power-up load ends are dropped; the
	// host must wait for init_done before its first frame
	// the link has three inputs only and nothing is driven back

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	reg  [1:0] clk_sync_q;
	reg  [1:0] dat_sync_q;
	reg  [1:0] cs_sync_q;
	reg        clk_prev_q;
	reg        cs_prev_q;
	reg        dat_prev_q;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_sync_q <= 2'h0;
			dat_sync_q <= 2'h0;
			cs_sync_q  <= 2'h3;
			clk_prev_q <= 1'b0;
			cs_prev_q  <= 1'b1;
			dat_prev_q <= 1'b0;
		end else begin
			clk_sync_q <= {clk_sync_q[0], ser_clk};
			dat_sync_q <= {dat_sync_q[0], ser_data};
			cs_sync_q  <= {cs_sync_q[0], ser_cs_n};
			clk_prev_q <= clk_sync_q[1];
			cs_prev_q  <= cs_sync_q[1];
			dat_prev_q <= dat_sync_q[1];
		end
	end

	// data is taken one stage late so it lines up with the edge detect;
	// with zero hold time at the pin this keeps the pre-edge value
	wire clk_rise = clk_sync_q[1] & ~clk_prev_q;
	wire cs_low   = ~cs_sync_q[1];
	wire cs_rise  = cs_sync_q[1] & ~cs_prev_q;

	// --------------------------------------------------------------
	// shift register and frame counter
	// --------------------------------------------------------------
	reg [15:0] shift_q;
	reg [4:0]  count_q;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_q <= 16'h0000;
			count_q <= 5'h00;
		end else if (cs_low && init_done) begin
			if (clk_rise) begin
				shift_q <= {shift_q[14:0], dat_prev_q};
				// saturate past sixteen so long frames are rejected
				if (count_q != `DPSC_CNT_SAT)
					count_q <= count_q + 5'h01;
			end
		end else begin
			count_q <= 5'h00;
		end
	end

	// --------------------------------------------------------------
	// frame decode
	// --------------------------------------------------------------
	function [1:0] dpsc_pick;
		input [15:0] frm;
		input        long;
		input        hi_field;
		begin
			if (long)
				dpsc_pick = hi_field ? {frm[`DPSC_CMD_HI_L], frm[`DPSC_CMD_LO_L]}
				                     : {frm[`DPSC_SEL_HI_L], frm[`DPSC_SEL_LO_L]};
			else
				dpsc_pick = hi_field ? {frm[`DPSC_CMD_HI_S], frm[`DPSC_CMD_LO_S]}
				                     : {frm[`DPSC_SEL_HI_S], frm[`DPSC_SEL_LO_S]};
		end
	endfunction

	wire       is_long  = (count_q == `DPSC_CNT_LONG);
	wire       is_short = (count_q == `DPSC_CNT_SHORT);
	wire [1:0] cmd      = dpsc_pick(shift_q, is_long, 1'b1);
	wire [1:0] sel      = dpsc_pick(shift_q, is_long, 1'b0);
	wire [7:0] code     = shift_q[7:0];
	wire       is_copy  = cmd[1];
	// write commands need the data byte; copies take either length
	wire       len_ok   = is_long | (is_short & is_copy);
	wire       sel_ok   = (sel == `DPSC_SEL_A) | (sel == `DPSC_SEL_B) |
	                      ((sel == `DPSC_SEL_BOTH) & is_copy);
	wire       go       = cs_rise & init_done & len_ok & sel_ok;
	wire       hit_a    = sel[0];
	wire       hit_b    = sel[1];

	// --------------------------------------------------------------
	// decoded command strobes
	// --------------------------------------------------------------
	// one strobe per command keeps the register update below readable
	wire       do_wiper  = go & (cmd == `DPSC_CMD_WR_WIPER);
	wire       do_stored = go & (cmd == `DPSC_CMD_WR_STORED);
	wire       do_to_nv  = go & (cmd == `DPSC_CMD_CP_TO_NV);
	wire       do_to_wip = go & (cmd == `DPSC_CMD_CP_TO_WIP);
	// both stored-copy writes raise the busy pulse
	wire       nv_write  = do_stored | do_to_nv;

	// --------------------------------------------------------------
	// power-up load timer and stored-copy busy pulse
	// --------------------------------------------------------------
	reg [9:0] init_cnt_q;

	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_cnt_q <= 10'h000;
			init_done  <= 1'b0;
		end else if (!init_done) begin
			// load is done once the count expires, inside 5 us
			if (init_cnt_q == `DPSC_INIT_CYC - 1)
				init_done <= 1'b1;
			else
				init_cnt_q <= init_cnt_q + 10'h001;
		end
	end

	// busy is a one-cycle pulse after each stored-copy write; the store itself is immediate
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			store_busy <= 1'b0;
		else
			store_busy <= nv_write;
	end

	// --------------------------------------------------------------
	// potentiometer registers; no readback path exists
	// --------------------------------------------------------------
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wiper_position_a  <= `DPSC_STORED_RESET;
			wiper_position_b  <= `DPSC_STORED_RESET;
			stored_position_a <= `DPSC_STORED_RESET;
			stored_position_b <= `DPSC_STORED_RESET;
		end else if (!init_done) begin
			wiper_position_a <= stored_position_a;
			wiper_position_b <= stored_position_b;
		end else begin
			// a frame carries one command, so at most one strobe is high;
			// wipers and stored copies are updated in separate chains
			if (do_wiper) begin
				if (hit_a) wiper_position_a <= code;
				if (hit_b) wiper_position_b <= code;
			end else if (do_to_wip) begin
				if (hit_a) wiper_position_a <= stored_position_a;
				if (hit_b) wiper_position_b <= stored_position_b;
			end
			if (do_stored) begin
				if (hit_a) stored_position_a <= code;
				if (hit_b) stored_position_b <= code;
			end else if (do_to_nv) begin
				if (hit_a) stored_position_a <= wiper_position_a;
				if (hit_b) stored_position_b <= wiper_position_b;
			end
		end
	end

endmodule

// >>> rtl/dpsc_defs.vh
// constants for the dual potentiometer serial command controller
`ifndef DPSC_DEFS_VH
`define DPSC_DEFS_VH

`define DPSC_CMD_WR_WIPER   2'h0
`define DPSC_CMD_WR_STORED  2'h1
`define DPSC_CMD_CP_TO_NV   2'h2
`define DPSC_CMD_CP_TO_WIP  2'h3

`define DPSC_SEL_A          2'h1
`define DPSC_SEL_B          2'h2
`define DPSC_SEL_BOTH       2'h3

`define DPSC_CNT_SHORT      5'h08
`define DPSC_CNT_LONG       5'h10
// the frame counter stops here so frames longer than sixteen stay invalid
`define DPSC_CNT_SAT        5'h1f

// frame bit positions in a 16-bit frame (bit 15 = first edge)
`define DPSC_CMD_HI_L       13
`define DPSC_CMD_LO_L       12
`define DPSC_SEL_HI_L       9
`define DPSC_SEL_LO_L       8
// in an 8-bit frame the same fields sit eight places lower
`define DPSC_CMD_HI_S       5
`define DPSC_CMD_LO_S       4
`define DPSC_SEL_HI_S       1
`define DPSC_SEL_LO_S       0

`define DPSC_STORED_RESET   8'h80
`define DPSC_INIT_NS        5000
`define DPSC_CLK_MHZ        125
// longest time: round down, at least one cycle
`define DPSC_INIT_CYC       ((`DPSC_INIT_NS * `DPSC_CLK_MHZ) / 1000)

`endif

// >>> dv/dpsc_host.sv
// serial host model driving the three-wire link
`timescale 1ns/1ps
module dpsc_host (
	input wire logic sys_clk,
	output logic     ser_clk = 1'b0,
	output logic     ser_data = 1'b0,
	output logic     ser_cs_n = 1'b1
);
	// link clock rests low between frames; a released data line shows the inverse of its last bit
	task automatic send(input logic [15:0] f, input int n);
		ser_cs_n <= 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			ser_data <= f[i];
			repeat (4) @(posedge sys_clk);
			ser_clk <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ser_clk <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		ser_cs_n <= 1'b1;
		ser_data <= ~ser_data;
		// stores land at once in this model, so a short gap stands for the busy time
		repeat (12) @(posedge sys_clk);
	endtask
endmodule

// >>> dv/dpsc_ctrl_asserts.sv
// checker on the pot controller ports
`timescale 1ns/1ps
module dpsc_ctrl_asserts (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       ser_cs_n,
	input wire logic       init_done,
	input wire logic       store_busy,
	input wire logic [7:0] wiper_position_a,
	input wire logic [7:0] wiper_position_b,
	input wire logic [7:0] stored_position_a,
	input wire logic [7:0] stored_position_b
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// pin select is async to us, so allow a small window after it rises
	sequence s_shut; ser_cs_n && $past(ser_cs_n, 2) && !$past(ser_cs_n, 6); endsequence
	sequence s_live; init_done && $past(init_done); endsequence
	property p_wa;
		s_live ##0 $changed({wiper_position_a, wiper_position_b}) |-> s_shut;
	endproperty
	a_wa: assert property (p_wa) else $error("wiper moved early");
	property p_sa;
		s_live ##0 $changed({stored_position_a, stored_position_b}) |-> s_shut ##0 store_busy;
	endproperty
	a_sa: assert property (p_sa) else $error("stored copy bad");
	property p_bz; store_busy |-> s_shut ##1 !store_busy; endproperty
	a_bz: assert property (p_bz) else $error("busy pulse bad");
	property p_vo;
		s_live ##0 $changed({wiper_position_a, wiper_position_b}) |-> $stable({stored_position_a, stored_position_b});
	endproperty
	a_vo: assert property (p_vo) else $error("stored moved with wiper");
	property p_cs;
		!ser_cs_n && !$past(ser_cs_n) |-> $stable({wiper_position_a, wiper_position_b});
	endproperty
	a_cs: assert property (p_cs) else $error("wiper moved in frame");
	property p_in; $fell(sys_rst) |-> !init_done [*8] ##[1:640] init_done; endproperty
	a_in: assert property (p_in) else $error("init time bad");
	property p_ld;
		$rose(init_done) |-> {wiper_position_a, wiper_position_b} == {stored_position_a, stored_position_b};
	endproperty
	a_ld: assert property (p_ld) else $error("wiper not loaded");
	property p_dn; init_done |=> init_done; endproperty
	a_dn: assert property (p_dn) else $error("init done dropped");
endmodule
bind dpsc_ctrl dpsc_ctrl_asserts u_chk (
	.sys_clk          (sys_clk),
	.sys_rst          (sys_rst),
	.ser_cs_n         (ser_cs_n),
	.init_done        (init_done),
	.store_busy       (store_busy),
	.wiper_position_a (wiper_position_a),
	.wiper_position_b (wiper_position_b),
	.stored_position_a(stored_position_a),
	.stored_position_b(stored_position_b)
);

// >>> dv/dpsc_ctrl_tb.sv
// self-checking bench for the pot controller
`timescale 1ns/1ps
module dpsc_ctrl_tb;
	logic       clk = 1'b0, rst = 1'b1, sck, sd, cs_n, done, busy;
	logic [7:0] wa, wb, sa, sb, code, w[2], s[2];
	logic [1:0] cmd, sel;
	integer     seed = 32'h96057fc1;
	int         num_errors = 0, n_tests = 0, cyc = 0, busy_n = 0, busy_exp = 0;
	always #4 clk = ~clk;
	dpsc_host host (.sys_clk(clk), .ser_clk(sck), .ser_data(sd), .ser_cs_n(cs_n));
	dpsc_ctrl dut (.sys_clk(clk), .sys_rst(rst), .ser_clk(sck), .ser_data(sd), .ser_cs_n(cs_n), .init_done(done),
		.store_busy(busy), .wiper_position_a(wa), .wiper_position_b(wb), .stored_position_a(sa), .stored_position_b(sb));
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic restart();
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		w[0] = 8'h80;
		w[1] = 8'h80;
		s[0] = 8'h80;
		s[1] = 8'h80;
		repeat (700) @(posedge clk);
		chk({done, wa, wb, sa, sb}, {1'b1, w[0], w[1], s[0], s[1]});
	endtask
	task automatic frame(input int n);
		host.send({2'h0, cmd, 2'h0, sel, code}, n);
		if ((n == 16 || (cmd[1] && n == 8)) && sel != 2'h0 && (cmd[1] || sel != 2'h3)) begin
			if (cmd == 2'h1 || cmd == 2'h2)
				busy_exp++;
			for (int p = 0; p < 2; p++)
				if (sel[p])
					case (cmd)
						2'h0: w[p] = code;
						2'h1: s[p] = code;
						2'h2: s[p] = w[p];
						default: w[p] = s[p];
					endcase
		end
		chk({done, wa, wb, sa, sb}, {1'b1, w[0], w[1], s[0], s[1]});
		chk(33'(busy_n), 33'(busy_exp));
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// each stored-copy write must show exactly one busy pulse
	always @(posedge clk) begin
		if (busy === 1'b1)
			busy_n <= busy_n + 1;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		restart();
		$display("power-up test done");
		for (int i = 0; i < 60; i++) begin
			cmd = i < 2 ? 2'h0 : 2'($random(seed));
			sel = i < 2 ? 2'(i + 1) : 2'($random(seed));
			code = i < 2 ? {8{i[0]}} : 8'($random(seed));
			frame(i < 2 ? 16 : (i % 5 == 4 ? 12 : (i % 3 == 0 ? 8 : 16)));
		end
		$display("frame test done");
		restart();
		$display("reset test done");
		test_done();
	end
endmodule
